// File: pkg/irq_regs_pkg.sv
`default_nettype none

package irq_regs_pkg;

    // Bus and data geometry
    localparam int ADDR_WIDTH  = 12;
    localparam int DATA_WIDTH  = 8;
    localparam int GROUP_WIDTH = 8;
    localparam int GROUP_COUNT = 3;
    localparam int SOURCE_COUNT = GROUP_WIDTH * GROUP_COUNT;
    localparam int INDEX_WIDTH = 5;
    localparam int PERIPH2_WIDTH = 4;
    localparam int PINC_WIDTH  = 4;

    // Register offsets
    localparam logic [ADDR_WIDTH-1:0] OFFSET_REQUEST_GROUP0      = 12'hfc0;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_ENABLE_HIGH_GROUP0  = 12'hfc1;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_ENABLE_LOW_GROUP0   = 12'hfc2;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_REQUEST_GROUP1_PINS = 12'hfc3;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_REQUEST_GROUP2      = 12'hfc6;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_EVENT_STATUS        = 12'hfd0;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_EVENT_MASK          = 12'hfd1;

    // Reset values
    localparam logic [GROUP_WIDTH-1:0] RESET_REQUEST = 8'h00;
    localparam logic [GROUP_WIDTH-1:0] RESET_ENABLE  = 8'h00;
    localparam logic [DATA_WIDTH-1:0]  RESET_READ    = 8'h00;

    // Event status / mask layout: one overrun bit per request group
    localparam int EVENT_WIDTH = 3;
    localparam int EVENT_BIT_OVERRUN_GROUP0 = 0;
    localparam int EVENT_BIT_OVERRUN_GROUP1 = 1;
    localparam int EVENT_BIT_OVERRUN_GROUP2 = 2;
    localparam logic [EVENT_WIDTH-1:0] RESET_EVENT = 3'h0;

    // Priority level encoding {enable high, enable low}
    typedef enum logic [1:0] {
        LEVEL_OFF     = 2'h0,
        LEVEL_LOW     = 2'h1,
        LEVEL_NOMINAL = 2'h2,
        LEVEL_HIGH    = 2'h3
    } level_e;

endpackage

`default_nettype wire

// File: core/irq_request_enable_regs.sv
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Watchdog interrupt never passes through these request or enable registers.
// - A request pulse sets its source bit in the request register.
// - Global enable on: pending enabled requests go to the core as vectored.
// - Global enable off: requests stay latched and readable for polling.
// - Group 0 bits 7..0: timer2, timer1, timer0, rx0, tx0, two-wire, SPI, converter.
// - Group 1 bit x holds the edge request of pin x, port A or D.
// - Per pin index, port select chooses A or D as the only feeder.
// - Group 2 bits 7..0: timer3, rx1, tx1, transfer engine, port C pins 3..0.
// - Enable pair high/low: 00 off, 01 level 1, 10 level 2, 11 level 3.
// - Group 0 enable bits map to the same sources as group 0 requests.
// - Acknowledge clears the request bit; writing 0 also clears it.
// - Writing 1 raises the request; acknowledge clears it later.
// - Level 3 beats level 2 beats level 1 regardless of source order.
// - Within one level, the lowest fixed vector position wins.
module irq_request_enable_regs
    import irq_regs_pkg::*;
(
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    // Register bus
    input  wire logic [ADDR_WIDTH-1:0]    regAddr,
    input  wire logic [DATA_WIDTH-1:0]    regWrData,
    input  wire logic                     regWrEn,
    input  wire logic                     regRdEn,
    output logic      [DATA_WIDTH-1:0]    regRdData,
    // One-cycle request pulses from same-clock logic
    input  wire logic [GROUP_WIDTH-1:0]   periph0Pulse,
    input  wire logic [PERIPH2_WIDTH-1:0] periph2Pulse,
    input  wire logic [GROUP_WIDTH-1:0]   portAEdgePulse,
    input  wire logic [GROUP_WIDTH-1:0]   portDEdgePulse,
    input  wire logic [PINC_WIDTH-1:0]    pinCEdgePulse,
    // Levels from control registers kept outside this block
    input  wire logic [GROUP_WIDTH-1:0]   portSelect,
    input  wire logic [GROUP_WIDTH-1:0]   enableHighGroup1,
    input  wire logic [GROUP_WIDTH-1:0]   enableLowGroup1,
    input  wire logic [GROUP_WIDTH-1:0]   enableHighGroup2,
    input  wire logic [GROUP_WIDTH-1:0]   enableLowGroup2,
    input  wire logic                     globalIrqEnable,
    // Core side
    input  wire logic                     ackValid,
    input  wire logic [INDEX_WIDTH-1:0]   ackIndex,
    output logic                          irqRequest,
    output logic      [INDEX_WIDTH-1:0]   irqVector,
    output logic      [1:0]               irqLevel,
    output logic                          irqEvent
);

    // Request and enable state
    logic [GROUP_WIDTH-1:0] requestGroup0_reg;
    logic [GROUP_WIDTH-1:0] requestGroup0_next;
    logic [GROUP_WIDTH-1:0] requestGroup1Pins_reg;
    logic [GROUP_WIDTH-1:0] requestGroup1Pins_next;
    logic [GROUP_WIDTH-1:0] requestGroup2_reg;
    logic [GROUP_WIDTH-1:0] requestGroup2_next;
    logic [GROUP_WIDTH-1:0] enableHighGroup0_reg;
    logic [GROUP_WIDTH-1:0] enableHighGroup0_next;
    logic [GROUP_WIDTH-1:0] enableLowGroup0_reg;
    logic [GROUP_WIDTH-1:0] enableLowGroup0_next;

    // Event status and mask
    logic [EVENT_WIDTH-1:0] eventStatus_reg;
    logic [EVENT_WIDTH-1:0] eventStatus_next;
    logic [EVENT_WIDTH-1:0] eventMask_reg;
    logic [EVENT_WIDTH-1:0] eventMask_next;

    // Outputs
    logic [DATA_WIDTH-1:0]  regRdData_reg;
    logic [DATA_WIDTH-1:0]  regRdData_next;
    logic                   irqRequest_reg;
    logic                   irqRequest_next;
    logic [INDEX_WIDTH-1:0] irqVector_reg;
    logic [INDEX_WIDTH-1:0] irqVector_next;
    logic [1:0]             irqLevel_reg;
    logic [1:0]             irqLevel_next;
    logic                   irqEvent_reg;
    logic                   irqEvent_next;

    // Combinational helpers
    logic [GROUP_WIDTH-1:0]  pinPulse;
    logic [GROUP_WIDTH-1:0]  group2Pulse;
    logic [GROUP_WIDTH-1:0]  ackClear0;
    logic [GROUP_WIDTH-1:0]  ackClear1;
    logic [GROUP_WIDTH-1:0]  ackClear2;
    logic [SOURCE_COUNT-1:0] pendingFlat;
    // Flat view: index is group times eight plus seven minus bit
    logic [1:0]              levelFlat [SOURCE_COUNT];
    logic                    bestFound;
    logic [INDEX_WIDTH-1:0]  bestIndex;
    logic [1:0]              bestLevel;

    // Only the watchdog bypasses this block; it has no input here

    // One port per pin index, chosen by the select bit
    // Edges on the deselected port are dropped, not held for later
    assign pinPulse    = (portSelect & portDEdgePulse) | (~portSelect & portAEdgePulse);
    assign group2Pulse = {periph2Pulse, pinCEdgePulse};

    // Flattened priority order: index 0 is the lowest vector position
    // Ack indices 24 to 31 match no bit and are ignored
    genvar g;
    generate
        for (g = 0; g < GROUP_WIDTH; g++) begin : gen_flat
            assign ackClear0[GROUP_WIDTH-1-g] = ackValid
                && (ackIndex == INDEX_WIDTH'(g));
            assign ackClear1[GROUP_WIDTH-1-g] = ackValid
                && (ackIndex == INDEX_WIDTH'(g + GROUP_WIDTH));
            assign ackClear2[GROUP_WIDTH-1-g] = ackValid
                && (ackIndex == INDEX_WIDTH'(g + 2 * GROUP_WIDTH));
            assign pendingFlat[g]                 = requestGroup0_reg[GROUP_WIDTH-1-g];
            assign pendingFlat[g + GROUP_WIDTH]   = requestGroup1Pins_reg[GROUP_WIDTH-1-g];
            assign pendingFlat[g + 2*GROUP_WIDTH] = requestGroup2_reg[GROUP_WIDTH-1-g];
            assign levelFlat[g] = {enableHighGroup0_reg[GROUP_WIDTH-1-g],
                                   enableLowGroup0_reg[GROUP_WIDTH-1-g]};
            assign levelFlat[g + GROUP_WIDTH] = {enableHighGroup1[GROUP_WIDTH-1-g],
                                                 enableLowGroup1[GROUP_WIDTH-1-g]};
            assign levelFlat[g + 2*GROUP_WIDTH] = {enableHighGroup2[GROUP_WIDTH-1-g],
                                                   enableLowGroup2[GROUP_WIDTH-1-g]};
        end
    endgenerate

    // Request latching; write replaces, ack clears, pulse sets last so it wins
    always_comb begin
        requestGroup0_next     = requestGroup0_reg;
        requestGroup1Pins_next = requestGroup1Pins_reg;
        requestGroup2_next     = requestGroup2_reg;
        // A write replaces the whole register; software rewrites all eight bits
        if (regWrEn) begin
            case (regAddr)
                OFFSET_REQUEST_GROUP0:      requestGroup0_next = regWrData;
                OFFSET_REQUEST_GROUP1_PINS: requestGroup1Pins_next = regWrData;
                OFFSET_REQUEST_GROUP2:      requestGroup2_next = regWrData;
                default: ;
            endcase
        end
        requestGroup0_next     = requestGroup0_next & ~ackClear0;
        requestGroup1Pins_next = requestGroup1Pins_next & ~ackClear1;
        requestGroup2_next     = requestGroup2_next & ~ackClear2;
        // Pulse after ack, so a fresh request is never eaten by a late ack
        // Latched whatever the global enable, so polling sees them
        requestGroup0_next     = requestGroup0_next | periph0Pulse;
        requestGroup1Pins_next = requestGroup1Pins_next | pinPulse;
        requestGroup2_next     = requestGroup2_next | group2Pulse;
    end

    // Enable registers
    // Group 1 and 2 pairs come in as ports; their registers live outside
    always_comb begin
        enableHighGroup0_next = enableHighGroup0_reg;
        enableLowGroup0_next  = enableLowGroup0_reg;
        if (regWrEn && regAddr == OFFSET_ENABLE_HIGH_GROUP0) begin
            enableHighGroup0_next = regWrData;
        end
        if (regWrEn && regAddr == OFFSET_ENABLE_LOW_GROUP0) begin
            enableLowGroup0_next = regWrData;
        end
    end

    // Arbitration: scan from highest index downward; >= lets ties end on the lower index
    // Linear scan over 24 sources in one cycle; a tree would cut depth for area
    always_comb begin
        bestFound = 1'b0;
        bestIndex = '0;
        bestLevel = LEVEL_OFF;
        for (int i = SOURCE_COUNT - 1; i >= 0; i--) begin
            if (pendingFlat[i] && levelFlat[i] != LEVEL_OFF
                    && levelFlat[i] >= bestLevel) begin
                bestFound = 1'b1;
                bestIndex = INDEX_WIDTH'(i);
                bestLevel = levelFlat[i];
            end
        end
    end

    always_comb begin
        // Withheld while globally disabled; the latched bits still stand
        // Registered, so an ack shows on these outputs one cycle late
        irqRequest_next = globalIrqEnable && bestFound;
        irqVector_next  = bestIndex;
        irqLevel_next   = bestLevel;
    end

    // Overrun: a pulse hitting a bit that is already pending merges and is lost
    always_comb begin
        eventStatus_next = eventStatus_reg;
        eventMask_next   = eventMask_reg;
        if (regWrEn && regAddr == OFFSET_EVENT_STATUS) begin
            // Write-one-to-clear: a read-modify-write cannot wipe a new event
            eventStatus_next = eventStatus_reg & ~regWrData[EVENT_WIDTH-1:0];
        end
        if (regWrEn && regAddr == OFFSET_EVENT_MASK) begin
            eventMask_next = regWrData[EVENT_WIDTH-1:0];
        end
        // Set after clear so a same-cycle event survives
        if (|(periph0Pulse & requestGroup0_reg)) begin
            eventStatus_next[EVENT_BIT_OVERRUN_GROUP0] = 1'b1;
        end
        if (|(pinPulse & requestGroup1Pins_reg)) begin
            eventStatus_next[EVENT_BIT_OVERRUN_GROUP1] = 1'b1;
        end
        if (|(group2Pulse & requestGroup2_reg)) begin
            eventStatus_next[EVENT_BIT_OVERRUN_GROUP2] = 1'b1;
        end
        // Mask gates only the output; status still latches while masked
        irqEvent_next = |(eventStatus_next & eventMask_next);
    end

    // Read data shows the register value before the same-cycle update
    // Unmapped addresses read zero and nothing flags them
    always_comb begin
        regRdData_next = RESET_READ;
        if (regRdEn) begin
            case (regAddr)
                OFFSET_REQUEST_GROUP0:      regRdData_next = requestGroup0_reg;
                OFFSET_ENABLE_HIGH_GROUP0:  regRdData_next = enableHighGroup0_reg;
                OFFSET_ENABLE_LOW_GROUP0:   regRdData_next = enableLowGroup0_reg;
                OFFSET_REQUEST_GROUP1_PINS: regRdData_next = requestGroup1Pins_reg;
                OFFSET_REQUEST_GROUP2:      regRdData_next = requestGroup2_reg;
                OFFSET_EVENT_STATUS:
                    regRdData_next = {{(DATA_WIDTH-EVENT_WIDTH){1'b0}}, eventStatus_reg};
                OFFSET_EVENT_MASK:
                    regRdData_next = {{(DATA_WIDTH-EVENT_WIDTH){1'b0}}, eventMask_reg};
                default:                    regRdData_next = RESET_READ;
            endcase
        end
    end

    // Request registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            requestGroup0_reg     <= RESET_REQUEST;
            requestGroup1Pins_reg <= RESET_REQUEST;
            requestGroup2_reg     <= RESET_REQUEST;
        end else begin
            requestGroup0_reg     <= requestGroup0_next;
            requestGroup1Pins_reg <= requestGroup1Pins_next;
            requestGroup2_reg     <= requestGroup2_next;
        end
    end

    // Group 0 enables reset to off, so no group 0 source is offered before software sets a level
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enableHighGroup0_reg <= RESET_ENABLE;
            enableLowGroup0_reg  <= RESET_ENABLE;
        end else begin
            enableHighGroup0_reg <= enableHighGroup0_next;
            enableLowGroup0_reg  <= enableLowGroup0_next;
        end
    end

    // Event status, mask and level interrupt
    // Interrupt is built from next values, so it lines up with the status bits
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            eventStatus_reg <= RESET_EVENT;
            eventMask_reg   <= RESET_EVENT;
            irqEvent_reg    <= 1'b0;
        end else begin
            eventStatus_reg <= eventStatus_next;
            eventMask_reg   <= eventMask_next;
            irqEvent_reg    <= irqEvent_next;
        end
    end

    // Read data stands for one cycle only
    // Idle zero lets several slaves be ORed onto one bus without a select
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            regRdData_reg <= RESET_READ;
        end else begin
            regRdData_reg <= regRdData_next;
        end
    end

    // Offer to the core
    // Vector and level are valid only while the request stands
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqRequest_reg <= 1'b0;
            irqVector_reg  <= '0;
            irqLevel_reg   <= LEVEL_OFF;
        end else begin
            irqRequest_reg <= irqRequest_next;
            irqVector_reg  <= irqVector_next;
            irqLevel_reg   <= irqLevel_next;
        end
    end

    assign regRdData  = regRdData_reg;
    assign irqRequest = irqRequest_reg;
    assign irqVector  = irqVector_reg;
    assign irqLevel   = irqLevel_reg;
    assign irqEvent   = irqEvent_reg;

endmodule

`default_nettype wire

// File: verification/irq_request_enable_regs_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module irq_request_enable_regs_asserts
    import irq_regs_pkg::*;
(
    input wire logic                     clk_sys,
    input wire logic                     rst,
    input wire logic [ADDR_WIDTH-1:0]    regAddr,
    input wire logic                     regWrEn,
    input wire logic                     regRdEn,
    input wire logic [DATA_WIDTH-1:0]    regRdData,
    input wire logic [GROUP_WIDTH-1:0]   periph0Pulse,
    input wire logic [PERIPH2_WIDTH-1:0] periph2Pulse,
    input wire logic [GROUP_WIDTH-1:0]   portAEdgePulse,
    input wire logic [GROUP_WIDTH-1:0]   portDEdgePulse,
    input wire logic [PINC_WIDTH-1:0]    pinCEdgePulse,
    input wire logic [GROUP_WIDTH-1:0]   portSelect,
    input wire logic                     globalIrqEnable,
    input wire logic                     ackValid,
    input wire logic                     irqRequest,
    input wire logic [INDEX_WIDTH-1:0]   irqVector,
    input wire logic [1:0]               irqLevel
);
    // Nothing may clear a bit between its pulse and the read
    wire logic quiet = !regWrEn && !ackValid;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    chk_req_gated: assert property (!globalIrqEnable |=> !irqRequest)
        else $error("request raised while globally disabled");
    chk_level_valid: assert property (irqRequest |-> irqLevel != LEVEL_OFF)
        else $error("request offered with level off");
    chk_vector_range: assert property (irqRequest |-> irqVector < SOURCE_COUNT)
        else $error("vector outside source range");
    chk_read_idle: assert property (!regRdEn |=> regRdData == 8'h00)
        else $error("read data not zero outside read slot");
    chk_pulse_group0: assert property (
        periph0Pulse[7] ##1 quiet ##1 (regRdEn && regAddr == OFFSET_REQUEST_GROUP0)
        |=> regRdData[7]) else $error("timer pulse not latched");
    chk_pulse_group2: assert property (
        periph2Pulse[3] ##1 quiet ##1 (regRdEn && regAddr == OFFSET_REQUEST_GROUP2)
        |=> regRdData[7]) else $error("group2 top pulse not latched");
    chk_pin_c: assert property (
        pinCEdgePulse[0] ##1 quiet ##1 (regRdEn && regAddr == OFFSET_REQUEST_GROUP2)
        |=> regRdData[0]) else $error("pin c pulse not latched");
    chk_port_a: assert property (
        (portAEdgePulse[4] && !portSelect[4]) ##1 quiet ##1
        (regRdEn && regAddr == OFFSET_REQUEST_GROUP1_PINS) |=> regRdData[4])
        else $error("selected port a pulse not latched");
    chk_port_d: assert property (
        (portDEdgePulse[1] && portSelect[1]) ##1 quiet ##1
        (regRdEn && regAddr == OFFSET_REQUEST_GROUP1_PINS) |=> regRdData[1])
        else $error("selected port d pulse not latched");
    chk_reset_clear: assert property (
        $fell(rst) |-> !irqRequest && irqLevel == LEVEL_OFF && regRdData == 8'h00)
        else $error("outputs not cleared by reset");
endmodule
bind irq_request_enable_regs irq_request_enable_regs_asserts i_chk (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .periph0Pulse(periph0Pulse), .periph2Pulse(periph2Pulse),
    .portAEdgePulse(portAEdgePulse), .portDEdgePulse(portDEdgePulse),
    .pinCEdgePulse(pinCEdgePulse), .portSelect(portSelect), .globalIrqEnable(globalIrqEnable),
    .ackValid(ackValid), .irqRequest(irqRequest), .irqVector(irqVector), .irqLevel(irqLevel));
`default_nettype wire

// File: verification/core_ack_model.sv
`timescale 1ns/100ps
`default_nettype none
module core_ack_model
    import irq_regs_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic                   serviceNow,
    input  wire logic                   irqRequest,
    input  wire logic [INDEX_WIDTH-1:0] irqVector,
    output logic                        ackValid,
    output logic      [INDEX_WIDTH-1:0] ackIndex
);
    // Acks only the vector on offer; idle index is scrambled, never the last one
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ackValid <= 1'b0;
            ackIndex <= '0;
        end else begin
            ackValid <= serviceNow && irqRequest;
            ackIndex <= (serviceNow && irqRequest) ? irqVector : ~irqVector;
        end
    end
endmodule
`default_nettype wire

// File: verification/irq_request_enable_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module irq_request_enable_regs_tb
    import irq_regs_pkg::*;
;
    logic                   clk_sys, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
    logic                   globalIrqEnable = 1'b0, serviceNow = 1'b0, ackValid;
    logic                   irqRequest, irqEvent;
    logic [ADDR_WIDTH-1:0]  regAddr = '0;
    logic [DATA_WIDTH-1:0]  regWrData = '0, regRdData;
    logic [GROUP_WIDTH-1:0] periph0Pulse = '0, portAEdgePulse = '0, portDEdgePulse = '0;
    logic [GROUP_WIDTH-1:0] portSelect = '0, enHigh1 = '0, enLow1 = '0, enHigh2 = '0, enLow2 = '0;
    logic [3:0]             periph2Pulse = '0, pinCEdgePulse = '0;
    logic [INDEX_WIDTH-1:0] ackIndex, irqVector;
    logic [1:0]             irqLevel;
    int                     miscompares = 0, checked = 0;
    logic [11:0] regMap [7] = '{12'hfc0, 12'hfc1, 12'hfc2, 12'hfc3, 12'hfc6, 12'hfd0, 12'h000};
    // {request, level, vector} in the order the core should be offered them
    logic [7:0]  order [6] = '{8'he6, 8'he7, 8'hec, 8'hd0, 8'ha0, 8'hb7};

    irq_request_enable_regs i_dut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .periph0Pulse(periph0Pulse), .periph2Pulse(periph2Pulse),
        .portAEdgePulse(portAEdgePulse), .portDEdgePulse(portDEdgePulse),
        .pinCEdgePulse(pinCEdgePulse), .portSelect(portSelect), .enableHighGroup1(enHigh1),
        .enableLowGroup1(enLow1), .enableHighGroup2(enHigh2), .enableLowGroup2(enLow2),
        .globalIrqEnable(globalIrqEnable), .ackValid(ackValid), .ackIndex(ackIndex),
        .irqRequest(irqRequest), .irqVector(irqVector), .irqLevel(irqLevel), .irqEvent(irqEvent));
    core_ack_model i_core (.clk_sys(clk_sys), .rst(rst), .serviceNow(serviceNow),
        .irqRequest(irqRequest), .irqVector(irqVector), .ackValid(ackValid), .ackIndex(ackIndex));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checked++;
        if (seen !== want) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] want);
        @(posedge clk_sys);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        @(negedge clk_sys);
        check(regRdData, want);
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
    endtask
    // Layout: group0, group2 upper, pin C, port A, port D
    task automatic pulse(input logic [31:0] v);
        @(posedge clk_sys);
        {periph0Pulse, periph2Pulse, pinCEdgePulse, portAEdgePulse, portDEdgePulse} <= v;
        @(posedge clk_sys);
        {periph0Pulse, periph2Pulse, pinCEdgePulse, portAEdgePulse, portDEdgePulse} <= '0;
    endtask
    task automatic results;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (regMap[i]) rd(regMap[i], 8'h00);
        $display("reset test done");
        pulse({8'h81, 24'h0});
        rd(12'hfc0, 8'h81);
        pulse({8'h00, 4'h9, 4'h1, 16'h0});
        rd(12'hfc6, 8'h91);
        portSelect <= 8'h0f;
        pulse({16'h0, 8'h39, 8'hc6});
        rd(12'hfc3, 8'h36);
        // Each pulse hits a bit already pending: one overrun per group
        pulse({8'h01, 4'h0, 4'h1, 8'h00, 8'h02});
        rd(12'hfd0, 8'h07);
        @(negedge clk_sys) check({7'h0, irqEvent}, 8'h00);
        wr(12'hfd1, 8'h01);
        repeat (2) @(negedge clk_sys);
        check({7'h0, irqEvent}, 8'h01);
        wr(12'hfd0, 8'h07);
        wr(12'hfd1, 8'h00);
        rd(12'hfd0, 8'h00);
        @(negedge clk_sys) check({7'h0, irqEvent}, 8'h00);
        $display("polling test done");
        fork
            wr(12'hfc0, 8'h00);
            pulse({8'h04, 24'h0});
        join
        rd(12'hfc0, 8'h04);
        wr(12'hfc0, 8'h00);
        wr(12'hfc3, 8'h00);
        rd(12'hfc0, 8'h00);
        rd(12'hfc3, 8'h00);
        $display("clear test done");
        wr(12'hfc1, 8'h03);
        wr(12'hfc2, 8'h83);
        // Group 1 pin 3 at level 3, group 2 timer 3 at level 2, pin C0 at level 1
        {enHigh1, enLow1, enHigh2, enLow2} <= 32'h0808_8001;
        wr(12'hfc3, 8'h08);
        wr(12'hfc6, 8'h81);
        wr(12'hfc0, 8'h83);
        rd(12'hfc1, 8'h03);
        rd(12'hfc2, 8'h83);
        @(negedge clk_sys) check({7'h0, irqRequest}, 8'h00);
        @(posedge clk_sys) globalIrqEnable <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            repeat (3) @(negedge clk_sys);
            check({irqRequest, irqLevel, irqVector}, order[i]);
            @(posedge clk_sys) serviceNow <= 1'b1;
            @(posedge clk_sys) serviceNow <= 1'b0;
        end
        repeat (4) @(negedge clk_sys);
        check({7'h0, irqRequest}, 8'h00);
        rd(12'hfc0, 8'h00);
        rd(12'hfc3, 8'h00);
        rd(12'hfc6, 8'h00);
        $display("priority test done");
        results();
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        miscompares++;
        results();
    end
endmodule
`default_nettype wire
